// ==== tb.sv ====
/*
 * Self-checking bench for the serial control block.
 * Assumes a pull-up on the transmit line and the remote node model beside it.
 */
`include "ucb_consts.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        rst_b;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        addr_bit_mode;
	logic        rx_char_done;
	logic [7:0]  rx_char_data;
	logic        rx_char_addr_bit;
	logic        rx_char_frame_bad;
	logic        rx_char_parity_bad;
	logic        rx_idle_seen;
	logic        rx_break_seen;
	logic        tx_o;
	logic        tx_oe;
	logic        sclk_o;
	logic        sclk_oe;
	logic        tx_irq;
	logic        rx_irq;
	logic        rx_err_irq;
	logic        wake_tmp;
	logic [15:0] bit_clks;
	logic [7:0]  rx_data;
	logic        rx_addr;
	logic        rx_ok;
	logic [31:0] start_cyc;
	logic [31:0] cyc;
	logic [15:0] frame_cnt;
	wire         tx_line = tx_oe ? tx_o : 1'b1;
	int          bad_count;
	int          checked;

	ucb_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_bit_mode(addr_bit_mode),
		.rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
		.rx_char_addr_bit(rx_char_addr_bit), .rx_char_parity_bad(rx_char_parity_bad),
		.rx_char_frame_bad(rx_char_frame_bad), .rx_break_seen(rx_break_seen),
		.rx_idle_seen(rx_idle_seen), .transmit_pin_o(tx_o), .transmit_pin_oe(tx_oe),
		.serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe), .tx_irq(tx_irq),
		.rx_irq(rx_irq), .rx_err_irq(rx_err_irq), .wake_temp_flag(wake_tmp));

	ucb_remote_node node_u (.clk(clk), .line(tx_line), .addr_mode(addr_bit_mode),
		.bit_clks(bit_clks), .rx_data(rx_data), .rx_addr(rx_addr), .rx_ok(rx_ok),
		.start_cyc(start_cyc), .cyc(cyc), .frame_cnt(frame_cnt));

	// ==================================================
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp, msg);
	endtask

	task automatic pulse(input logic [7:0] d, input logic a, input logic f, input logic b);
		@(posedge clk);
		rx_char_done <= !b;
		rx_break_seen <= b;
		rx_char_data <= d;
		rx_char_addr_bit <= a;
		rx_char_frame_bad <= f;
		rx_char_parity_bad <= f;
		@(posedge clk);
		rx_char_done <= 1'b0;
		rx_break_seen <= 1'b0;
		#1;
	endtask

	task automatic wait_frame(input logic [15:0] n);
		for (int i = 0; i < 4000 && frame_cnt == n; i++) @(posedge clk);
		check({7'h0, frame_cnt != n}, 8'h01, "frame arrival");
	endtask

	// gap counts clocks from buffer write to start bit
	task automatic tx_frame(input logic [7:0] d, input logic a, input int lo, input int hi);
		logic [15:0] n;
		int          g;
		n = frame_cnt;
		wr(`UCB_OFS_TXBUF, d);
		g = -int'(cyc);
		wait_frame(n);
		g = g + int'(start_cyc);
		check(rx_data, d, "frame data");
		check({7'h0, rx_ok}, 8'h01, "frame framing");
		check({7'h0, rx_addr}, {7'h0, a}, "address bit");
		check({7'h0, (g >= lo) && (g <= hi)}, 8'h01, "gap before start");
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset;
		rd_chk(`UCB_OFS_CTL1, 8'h00, "control one reset");
		rd_chk(`UCB_OFS_HBAUD, 8'h00, "divisor high reset");
		rd_chk(`UCB_OFS_LBAUD, 8'h00, "divisor low reset");
		rd_chk(`UCB_OFS_CTL2, 8'hc0, "control two reset");
		rd_chk(`UCB_OFS_RXST, 8'h00, "status reset");
		rd_chk(16'h7058, 8'h00, "unmapped read");
		check({7'h0, tx_irq}, 8'h00, "tx request off");
	endtask

	task automatic t_config;
		logic v;
		wr(`UCB_OFS_CTL1, 8'h13);
		wr(`UCB_OFS_HBAUD, 8'ha5);
		rd_chk(`UCB_OFS_HBAUD, 8'ha5, "divisor high");
		wr(`UCB_OFS_HBAUD, 8'h00);
		wr(`UCB_OFS_LBAUD, 8'h01);
		wr(`UCB_OFS_CTL2, 8'h03);
		wr(`UCB_OFS_CTL1, 8'h33);
		rd_chk(`UCB_OFS_CTL1, 8'h33, "control one");
		rd_chk(`UCB_OFS_CTL2, 8'hc3, "control two");
		check({7'h0, tx_irq}, 8'h01, "tx request");
		check({7'h0, sclk_oe}, 8'h01, "clock pin enable");
		v = sclk_o;
		repeat (16) @(posedge clk);
		#1;
		check({7'h0, sclk_o}, {7'h0, ~v}, "clock pin period");
	endtask

	task automatic t_tx;
		logic [15:0] n;
		tx_frame(8'ha5, 1'b0, 0, 40);
		wr(`UCB_OFS_CTL1, 8'h13);
		wr(`UCB_OFS_LBAUD, 8'h02);
		wr(`UCB_OFS_CTL1, 8'h33);
		bit_clks = 16'd24;
		tx_frame(8'h3c, 1'b0, 0, 56);
		wr(`UCB_OFS_CTL1, 8'h13);
		wr(`UCB_OFS_LBAUD, 8'h01);
		bit_clks = 16'd16;
		wr(`UCB_OFS_CTL1, 8'h31);
		n = frame_cnt;
		wr(`UCB_OFS_TXBUF, 8'h96);
		rd_chk(`UCB_OFS_CTL2, 8'h03, "buffer held full");
		check({7'h0, tx_irq}, 8'h00, "tx request while full");
		repeat (100) @(posedge clk);
		check({7'h0, frame_cnt == n}, 8'h01, "no frame while disabled");
		wr(`UCB_OFS_CTL1, 8'h33);
		wait_frame(n);
		check(rx_data, 8'h96, "held frame");
		n = frame_cnt;
		wr(`UCB_OFS_TXBUF, 8'h5a);
		wr(`UCB_OFS_CTL1, 8'h31);
		wait_frame(n);
		check(rx_data, 8'h5a, "frame after disable");
		wr(`UCB_OFS_CTL1, 8'h33);
		// the stop bit is still on the line when the node reports the frame
		repeat (16) @(posedge clk);
		rd_chk(`UCB_OFS_CTL2, 8'hc3, "transmitter empty");
	endtask

	task automatic t_wake;
		wr(`UCB_OFS_CTL1, 8'h3b);
		wr(`UCB_OFS_CTL1, 8'h33);
		rd_chk(`UCB_OFS_CTL1, 8'h3b, "wake set only");
		wr(`UCB_OFS_CTL1, 8'h1b);
		rd_chk(`UCB_OFS_CTL1, 8'h1b, "wake kept in soft reset");
		check({7'h0, sclk_oe}, 8'h01, "clock enable kept");
		wr(`UCB_OFS_CTL1, 8'h3b);
		tx_frame(8'h81, 1'b0, 176, 216);
		rd_chk(`UCB_OFS_CTL1, 8'h33, "wake taken by transfer");
		check({7'h0, wake_tmp}, 8'h01, "wake temp flag");
		addr_bit_mode <= 1'b1;
		wr(`UCB_OFS_CTL1, 8'h3b);
		tx_frame(8'h22, 1'b1, 0, 40);
		tx_frame(8'h23, 1'b0, 0, 40);
		addr_bit_mode <= 1'b0;
	endtask

	task automatic t_rx;
		pulse(8'h55, 1'b0, 1'b0, 1'b0);
		check({7'h0, rx_irq}, 8'h01, "receive request");
		rd_chk(`UCB_OFS_RXST, 8'h40, "char ready");
		rd_chk(`UCB_OFS_RXBUF, 8'h55, "receive data");
		rd_chk(`UCB_OFS_RXST, 8'h00, "ready cleared");
		pulse(8'h66, 1'b0, 1'b0, 1'b0);
		pulse(8'h67, 1'b0, 1'b0, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'hc8, "overrun");
		check({7'h0, rx_err_irq}, 8'h00, "error request masked");
		wr(`UCB_OFS_CTL1, 8'h73);
		check({7'h0, rx_err_irq}, 8'h01, "error request");
		wr(`UCB_OFS_CTL1, 8'h53);
		rd_chk(`UCB_OFS_RXST, 8'h00, "status soft reset");
		rd_chk(`UCB_OFS_CTL2, 8'hc3, "control two soft reset");
		pulse(8'h11, 1'b0, 1'b1, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'h00, "flags frozen");
		check({7'h0, rx_err_irq}, 8'h00, "no request in reset");
		wr(`UCB_OFS_CTL1, 8'h73);
		pulse(8'h00, 1'b0, 1'b0, 1'b1);
		check({7'h0, rx_irq}, 8'h01, "break request");
		rd_chk(`UCB_OFS_RXST, 8'ha0, "break flag");
		wr(`UCB_OFS_CTL1, 8'h53);
		wr(`UCB_OFS_CTL1, 8'h72);
		pulse(8'h12, 1'b0, 1'b1, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'h00, "receiver off");
		check({7'h0, rx_irq}, 8'h00, "no request when off");
		addr_bit_mode <= 1'b1;
		wr(`UCB_OFS_CTL1, 8'h57);
		wr(`UCB_OFS_CTL1, 8'h77);
		pulse(8'h13, 1'b0, 1'b1, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'h00, "asleep data byte");
		pulse(8'h14, 1'b1, 1'b0, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'h42, "asleep address byte");
		rd_chk(`UCB_OFS_CTL1, 8'h77, "sleep kept");
		rd_chk(`UCB_OFS_RXBUF, 8'h14, "address data");
		pulse(8'h15, 1'b1, 1'b1, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'hd6, "address byte errors");
		check({7'h0, rx_err_irq}, 8'h01, "error request on fault");
		rd_chk(`UCB_OFS_RXBUF, 8'h15, "faulty address data");
		@(posedge clk);
		addr_bit_mode <= 1'b0;
		rx_idle_seen <= 1'b1;
		@(posedge clk);
		rx_idle_seen <= 1'b0;
		pulse(8'h16, 1'b0, 1'b0, 1'b0);
		rd_chk(`UCB_OFS_RXST, 8'hd6, "idle wake flags");
		rd_chk(`UCB_OFS_RXBUF, 8'h16, "idle wake data");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==================================================
	// clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr_bit_mode = 1'b0;
		rx_char_done = 1'b0;
		rx_char_data = 8'h00;
		rx_char_addr_bit = 1'b0;
		rx_char_frame_bad = 1'b0;
		rx_char_parity_bad = 1'b0;
		rx_idle_seen = 1'b0;
		rx_break_seen = 1'b0;
		bit_clks = 16'd16;
		bad_count = 0;
		checked = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_config();
		t_tx();
		t_wake();
		t_rx();
		stop_test();
	end

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

endmodule // tb

`default_nettype wire

// ==== ucb_baud.sv ====
/*
 * Baud generator: one bit-rate tick every eight times (divisor plus one) clocks.
 * Assumes a divisor stable except on the cycles that raise restart.
 */
`include "ucb_consts.svh"
`default_nettype none

module ucb_baud
	import ucb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        restart,
	input  wire logic [15:0] divisor,
	output logic             bit_tick
);

	ucb_baud_type q;
	ucb_baud_type d;

	function automatic logic [18:0] ucb_reload(input logic [15:0] div);
		ucb_reload = 19'(({3'h0, div} + 19'h00001) * `UCB_BAUD_MULT) - 19'h00001;
	endfunction

	// ==================================================
	// counter
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (restart) begin
			d.cnt = ucb_reload(divisor);
		end else if (q.cnt == 19'h00000) begin
			d.cnt = ucb_reload(divisor);
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt - 19'h00001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bit_tick = q.tick;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	tick_spacing_a: assert property (bit_tick |=> !bit_tick[*7])
		else $error("bit ticks closer than eight clocks");

endmodule // ucb_baud

`default_nettype wire

// ==== ucb_consts.svh ====
/*
 * Offsets, field positions, reset values and counts for the serial control block.
 * Assumes inclusion by its bare name from each file that uses its macros.
 */
`ifndef UCB_CONSTS_SVH
`define UCB_CONSTS_SVH

// ==================================================
// register offsets
`define UCB_OFS_CTL1    16'h7051
`define UCB_OFS_HBAUD   16'h7052
`define UCB_OFS_LBAUD   16'h7053
`define UCB_OFS_CTL2    16'h7054
`define UCB_OFS_RXST    16'h7055
`define UCB_OFS_RXBUF   16'h7057
`define UCB_OFS_TXBUF   16'h7059

// ==================================================
// serial_control_one fields
`define UCB_C1_RECEIVER_ENABLE    0
`define UCB_C1_TRANSMITTER_ENABLE    1
`define UCB_C1_SLEEP    2
`define UCB_C1_WAKE     3
`define UCB_C1_CLKENA   4
`define UCB_C1_SRSTN    5
`define UCB_C1_ERRIE    6

// ==================================================
// serial_control_two and receive status fields
`define UCB_C2_TXIE     0
`define UCB_C2_RXIE     1
`define UCB_C2_EMPTY    6
`define UCB_C2_RDY      7
`define UCB_RS_WAKE     1
`define UCB_RS_PE       2
`define UCB_RS_OE       3
`define UCB_RS_FE       4
`define UCB_RS_BRK      5
`define UCB_RS_RDY      6
`define UCB_RS_ERR      7

// ==================================================
// reset values and counts
`define UCB_DIV_RST     16'h0000
`define UCB_BYTE_RST    8'h00
`define UCB_BAUD_MULT   19'h00008
`define UCB_IDLE_BITS   4'hb
`define UCB_DATA_BITS   4'h8

`endif

// ==== ucb_pkg.sv ====
/*
 * Types shared by the serial control block modules.
 * Assumes ucb_consts.svh is reachable by bare name.
 */
`default_nettype none

package ucb_pkg;

	// ==================================================
	// transmit shifter
	typedef enum logic [2:0] {
		TX_IDLE, TX_SYNC, TX_PRE, TX_START, TX_DATA, TX_ADDR, TX_STOP
	} ucb_tx_state_type;

	typedef struct packed {
		ucb_tx_state_type st;
		logic [3:0]       cnt;
		logic [7:0]       sh;
		logic             wake;
		logic             pin;
	} ucb_tx_type;

	// ==================================================
	// baud generator
	typedef struct packed {
		logic [18:0] cnt;
		logic        tick;
	} ucb_baud_type;

	// ==================================================
	// top level
	typedef struct packed {
		logic       rx_en;
		logic       tx_en;
		logic       sleep;
		logic       wake_req;
		logic       clk_en;
		logic       srst_n;
		logic       err_ie;
		logic       rx_ie;
		logic       tx_ie;
		logic [15:0] div;
		logic [7:0] txbuf;
		logic       buf_full;
		logic       armed;
		logic       wake_tmp;
		logic       rdy;
		logic       brk;
		logic       fe;
		logic       oe;
		logic       pe;
		logic       rwake;
		logic       idle_pend;
		logic [7:0] rxbuf;
		logic [7:0] rdata;
		logic       sclk;
	} ucb_top_type;

endpackage

`default_nettype wire

// ==== ucb_remote_node.sv ====
/*
 * Remote serial node: decodes the frames that appear on the transmit line.
 * Assumes an idle-high line and bit_clks clocks for each bit.
 */
`default_nettype none

module ucb_remote_node (
	input  wire logic        clk,
	input  wire logic        line,
	input  wire logic        addr_mode,
	input  wire logic [15:0] bit_clks,
	output logic      [7:0]  rx_data,
	output logic             rx_addr,
	output logic             rx_ok,
	output logic      [31:0] start_cyc,
	output logic      [31:0] cyc,
	output logic      [15:0] frame_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic start_lvl;

	initial begin
		cyc = 32'h0;
		forever begin
			@(posedge clk);
			cyc <= cyc + 32'h1;
		end
	end

	// ==================================================
	// frame decoder, sampling mid-bit
	initial begin
		frame_cnt = 16'h0;
		forever begin
			@(posedge clk);
			if (line === 1'b0) begin
				start_cyc = cyc;
				repeat (bit_clks / 2) @(posedge clk);
				start_lvl = line;
				for (int i = 0; i < 8; i++) begin
					repeat (bit_clks) @(posedge clk);
					rx_data[i] = line;
				end
				rx_addr = 1'b0;
				if (addr_mode) begin
					repeat (bit_clks) @(posedge clk);
					rx_addr = line;
				end
				repeat (bit_clks) @(posedge clk);
				rx_ok = (start_lvl === 1'b0) && (line === 1'b1);
				frame_cnt = frame_cnt + 16'h1;
			end
		end
	end

endmodule // ucb_remote_node

`default_nettype wire

// ==== ucb_top.sv ====
/*
 * Control, baud select and operating flags of an asynchronous serial unit.
 * Assumes a receiver on the same clock that reports each assembled character,
 * break and idle line as one-cycle pulses, and a format bit for the protocol.
 */
`include "ucb_consts.svh"
`default_nettype none

module ucb_top
	import ucb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        addr_bit_mode,
	input  wire logic        rx_char_done,
	input  wire logic [7:0]  rx_char_data,
	input  wire logic        rx_char_addr_bit,
	input  wire logic        rx_char_parity_bad,
	input  wire logic        rx_char_frame_bad,
	input  wire logic        rx_break_seen,
	input  wire logic        rx_idle_seen,
	output logic             transmit_pin_o,
	output logic             transmit_pin_oe,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             rx_err_irq,
	output logic             wake_temp_flag
);

	ucb_top_type q;
	ucb_top_type d;

	logic       bit_tick;
	logic       tx_busy;
	logic       tx_load;
	logic       addr_hit;
	logic       xfer;
	logic       rx_error;
	logic       tx_buffer_free;
	logic       tx_empty;
	logic       baud_restart;
	logic [7:0] rx_status;

	function automatic logic ucb_hit(input logic [15:0] a, input logic [15:0] ofs);
		ucb_hit = (a == ofs);
	endfunction

	// ==================================================
	// derived status
	assign tx_buffer_free = !q.buf_full;
	assign tx_empty = !q.buf_full && !tx_busy;
	assign rx_error = q.brk | q.fe | q.oe | q.pe;
	assign rx_status = {rx_error, q.rdy, q.brk, q.fe, q.oe, q.pe, q.rwake, 1'b0};
	// picks what counts as an address byte
	assign addr_hit = addr_bit_mode ? rx_char_addr_bit : q.idle_pend;
	// the enable is sampled when the character completes
	assign xfer = rx_char_done && q.rx_en && q.srst_n && (!q.sleep || addr_hit);
	// once written while enabled, a character still goes out
	assign tx_load = q.buf_full && (q.tx_en || q.armed) && !tx_busy && q.srst_n;
	assign baud_restart = !q.srst_n ||
		(reg_wr && (ucb_hit(reg_addr, `UCB_OFS_HBAUD) || ucb_hit(reg_addr, `UCB_OFS_LBAUD)));

	// ==================================================
	// register file and flags
	always_comb begin
		d = q;
		if (tx_load) begin
			d.buf_full = 1'b0;
			d.wake_tmp = q.wake_req;
			d.wake_req = 1'b0;
		end
		if (reg_wr) begin
			case (reg_addr)
				`UCB_OFS_CTL1: begin
					d.rx_en = reg_wdata[`UCB_C1_RECEIVER_ENABLE];
					d.tx_en = reg_wdata[`UCB_C1_TRANSMITTER_ENABLE];
					d.sleep = reg_wdata[`UCB_C1_SLEEP];
					// set wins over the transfer clear in the same cycle
					d.wake_req = d.wake_req | reg_wdata[`UCB_C1_WAKE];
					d.clk_en = reg_wdata[`UCB_C1_CLKENA];
					d.srst_n = reg_wdata[`UCB_C1_SRSTN];
					d.err_ie = reg_wdata[`UCB_C1_ERRIE];
				end
				`UCB_OFS_HBAUD: d.div[15:8] = reg_wdata;
				`UCB_OFS_LBAUD: d.div[7:0] = reg_wdata;
				`UCB_OFS_CTL2: begin
					d.rx_ie = reg_wdata[`UCB_C2_RXIE];
					d.tx_ie = reg_wdata[`UCB_C2_TXIE];
				end
				`UCB_OFS_TXBUF: begin
					d.txbuf = reg_wdata;
					d.buf_full = 1'b1;
					d.armed = q.tx_en;
				end
				default: begin
				end
			endcase
		end
		// receive side: a read clears, a new transfer in the same cycle wins
		if (reg_rd && ucb_hit(reg_addr, `UCB_OFS_RXBUF)) begin
			d.rdy = 1'b0;
			d.rwake = 1'b0;
		end
		if (rx_idle_seen) begin
			d.idle_pend = 1'b1;
		end
		if (xfer) begin
			d.rxbuf = rx_char_data;
			d.oe = q.oe | q.rdy;
			d.rdy = 1'b1;
			d.pe = q.pe | rx_char_parity_bad;
			d.fe = q.fe | rx_char_frame_bad;
			d.rwake = addr_bit_mode ? rx_char_addr_bit : q.idle_pend;
			d.idle_pend = 1'b0;
		end
		if (rx_break_seen && !q.sleep) begin
			d.brk = 1'b1;
		end
		// operating flags only; configuration and wake request untouched
		if (!q.srst_n) begin
			d.buf_full = 1'b0;
			d.armed = 1'b0;
			d.wake_tmp = 1'b0;
			d.rdy = 1'b0;
			d.brk = 1'b0;
			d.fe = 1'b0;
			d.oe = 1'b0;
			d.pe = 1'b0;
			d.rwake = 1'b0;
			d.idle_pend = 1'b0;
		end
		if (bit_tick && q.clk_en) begin
			d.sclk = !q.sclk;
		end else if (!q.clk_en) begin
			d.sclk = 1'b0;
		end
		d.rdata = `UCB_BYTE_RST;
		if (reg_rd) begin
			case (reg_addr)
				`UCB_OFS_CTL1: begin
					d.rdata = {1'b0, q.err_ie, q.srst_n, q.clk_en,
						q.wake_req, q.sleep, q.tx_en, q.rx_en};
				end
				`UCB_OFS_HBAUD: d.rdata = q.div[15:8];
				`UCB_OFS_LBAUD: d.rdata = q.div[7:0];
				`UCB_OFS_CTL2: begin
					d.rdata = {tx_buffer_free, tx_empty, 4'h0, q.rx_ie, q.tx_ie};
				end
				`UCB_OFS_RXST: d.rdata = rx_status;
				`UCB_OFS_RXBUF: d.rdata = q.rxbuf;
				`UCB_OFS_TXBUF: d.rdata = q.txbuf;
				default: d.rdata = `UCB_BYTE_RST;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.div <= `UCB_DIV_RST;
		end else begin
			q <= d;
		end
	end

	// ==================================================
	// baud generator and shifter
	ucb_baud u_baud (
		.clk      (clk),
		.rst_b    (rst_b),
		.restart  (baud_restart),
		.divisor  (q.div),
		.bit_tick (bit_tick)
	);

	ucb_txshift u_tx (
		.clk       (clk),
		.rst_b     (rst_b),
		.hold      (!q.srst_n),
		.bit_tick  (bit_tick),
		.load      (tx_load),
		.load_data (q.txbuf),
		.load_wake (q.wake_req),
		.addr_mode (addr_bit_mode),
		.busy      (tx_busy),
		.pin       (transmit_pin_o)
	);

	// ==================================================
	// outputs
	assign reg_rdata = q.rdata;
	assign transmit_pin_oe = q.tx_en || tx_busy || (q.armed && q.buf_full);
	assign serial_clock_pin_o = q.sclk;
	assign serial_clock_pin_oe = q.clk_en;
	// requests are levels; empty never raises one
	assign tx_irq = tx_buffer_free && q.tx_ie;
	assign rx_irq = q.rx_en && q.rx_ie && (q.rdy || q.brk);
	assign rx_err_irq = q.rx_en && q.err_ie && rx_error;
	assign wake_temp_flag = q.wake_tmp;

	// ==================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	srst_flags_a: assert property (!q.srst_n && !$past(q.srst_n) |->
		tx_buffer_free && tx_empty && rx_status == 8'h00)
		else $error("flags not at soft reset values");

	srst_config_a: assert property (!q.srst_n && !reg_wr |=>
		q.div == $past(q.div) && q.clk_en == $past(q.clk_en))
		else $error("soft reset changed configuration");

	wake_keep_a: assert property (q.wake_req && !tx_load |=> q.wake_req)
		else $error("wake request lost without transfer");

	wake_set_a: assert property (reg_wr && reg_addr == `UCB_OFS_CTL1 &&
		reg_wdata[`UCB_C1_WAKE] |=> q.wake_req)
		else $error("wake request not set");

	tx_buffer_free_clear_a: assert property (reg_wr && reg_addr == `UCB_OFS_TXBUF &&
		q.srst_n |=> !tx_buffer_free)
		else $error("buffer write left buffer free");

	tx_request_a: assert property (tx_load && q.tx_ie &&
		!(reg_wr && reg_addr == `UCB_OFS_TXBUF) |=> tx_irq)
		else $error("no transmit request after transfer");

	empty_busy_a: assert property (tx_busy |-> !tx_empty)
		else $error("empty while shifter busy");

	err_request_a: assert property (xfer && rx_char_parity_bad &&
		q.err_ie && !(reg_wr && reg_addr == `UCB_OFS_CTL1) |=> rx_err_irq)
		else $error("receive error raised no request");

	sleep_hold_a: assert property (q.srst_n && q.sleep && !addr_hit &&
		!(reg_rd && reg_addr == `UCB_OFS_RXBUF) |=> q.rdy == $past(q.rdy))
		else $error("receive ready changed while asleep");

	sleep_keep_a: assert property (q.sleep && !(reg_wr &&
		reg_addr == `UCB_OFS_CTL1) |=> q.sleep)
		else $error("sleep cleared without software");

	rx_block_a: assert property (rx_char_done && !q.rx_en |=>
		q.rxbuf == $past(q.rxbuf))
		else $error("transfer while receiver disabled");

	div_high_a: assert property (reg_wr && reg_addr == `UCB_OFS_HBAUD |=>
		q.div[15:8] == $past(reg_wdata) && q.div[7:0] == $past(q.div[7:0]))
		else $error("high divisor byte not stored");

	// ==================================================
	// checks on the low divisor byte, transfers and timing
	div_low_a: assert property (reg_wr && reg_addr == `UCB_OFS_LBAUD |=>
		q.div[7:0] == $past(reg_wdata) && q.div[15:8] == $past(q.div[15:8]))
		else $error("low divisor byte not stored");

	restart_gap_a: assert property (baud_restart |=> !bit_tick[*8])
		else $error("bit tick too soon after restart");

	hold_idle_a: assert property (!q.srst_n |=> !tx_busy && !bit_tick)
		else $error("shifter or baud counter ran in soft reset");

	clk_pin_off_a: assert property (!q.clk_en |=> !serial_clock_pin_o)
		else $error("clock pin active while disabled");

	tx_idle_line_a: assert property (!tx_busy |-> transmit_pin_o)
		else $error("transmit line low while shifter idle");

	armed_send_a: assert property (q.srst_n && q.armed && q.buf_full && !tx_busy |=>
		tx_busy)
		else $error("written character not sent after disable");

	tx_buffer_free_set_a: assert property (tx_load &&
		!(reg_wr && reg_addr == `UCB_OFS_TXBUF) |=> tx_buffer_free)
		else $error("buffer free not set on transfer");

	wake_copy_a: assert property (tx_load |=> wake_temp_flag == $past(q.wake_req))
		else $error("wake request not copied on transfer");

	char_take_a: assert property (rx_char_done && q.rx_en && q.srst_n && !q.sleep |=>
		q.rxbuf == $past(rx_char_data))
		else $error("completed character not transferred");

	sleep_addr_a: assert property (rx_char_done && q.rx_en && q.srst_n && q.sleep &&
		addr_hit |=> q.rdy)
		else $error("address byte did not update flags");

	rx_request_a: assert property (xfer && q.rx_ie && !(reg_wr &&
		(reg_addr == `UCB_OFS_CTL1 || reg_addr == `UCB_OFS_CTL2)) |=> rx_irq)
		else $error("receive request missing after transfer");

endmodule // ucb_top

`default_nettype wire

// ==== ucb_txshift.sv ====
/*
 * Transmit shifter: start bit, eight data bits lsb first, optional address bit, stop bit.
 * Assumes load is raised only while busy is low.
 */
`include "ucb_consts.svh"
`default_nettype none

module ucb_txshift
	import ucb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       hold,
	input  wire logic       bit_tick,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       load_wake,
	input  wire logic       addr_mode,
	output logic            busy,
	output logic            pin
);

	ucb_tx_type q;
	ucb_tx_type d;

	// ==================================================
	// frame sequencer
	always_comb begin
		d = q;
		case (q.st)
			TX_IDLE: begin
				d.pin = 1'b1;
				if (load) begin
					d.sh = load_data;
					d.wake = load_wake;
					d.st = TX_SYNC;
				end
			end
			// wait for a tick so every bit lasts one full bit time
			TX_SYNC: begin
				if (bit_tick) begin
					d.cnt = 4'h0;
					if (q.wake && !addr_mode) begin
						d.st = TX_PRE;
						d.pin = 1'b1;
					end else begin
						d.st = TX_START;
						d.pin = 1'b0;
					end
				end
			end
			TX_PRE: begin
				if (bit_tick) begin
					if (q.cnt == `UCB_IDLE_BITS - 4'h1) begin
						d.st = TX_START;
						d.pin = 1'b0;
					end else begin
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			TX_START: begin
				if (bit_tick) begin
					d.st = TX_DATA;
					d.pin = q.sh[0];
					d.sh = {1'b0, q.sh[7:1]};
					d.cnt = 4'h0;
				end
			end
			TX_DATA: begin
				if (bit_tick) begin
					if (q.cnt == `UCB_DATA_BITS - 4'h1) begin
						if (addr_mode) begin
							d.st = TX_ADDR;
							d.pin = q.wake;
						end else begin
							d.st = TX_STOP;
							d.pin = 1'b1;
						end
					end else begin
						d.pin = q.sh[0];
						d.sh = {1'b0, q.sh[7:1]};
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			TX_ADDR: begin
				if (bit_tick) begin
					d.st = TX_STOP;
					d.pin = 1'b1;
				end
			end
			TX_STOP: begin
				if (bit_tick) begin
					d.st = TX_IDLE;
				end
			end
			default: begin
				d.st = TX_IDLE;
				d.pin = 1'b1;
			end
		endcase
		if (hold) begin
			d = '0;
			d.pin = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.pin <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign busy = (q.st != TX_IDLE);
	assign pin = q.pin;

endmodule // ucb_txshift

`default_nettype wire
